// file: src/eid_pkg.sv
package eid_pkg;

    // apb map
    localparam logic [7:0] EID_OFF_CMD    = 8'h00;
    localparam logic [7:0] EID_OFF_ACC    = 8'h04;
    localparam logic [7:0] EID_OFF_FLAGS  = 8'h08;
    localparam logic [7:0] EID_OFF_TPLO   = 8'h0c;
    localparam logic [7:0] EID_OFF_TPHI   = 8'h10;
    localparam logic [7:0] EID_OFF_LATCH  = 8'h14;
    localparam logic [7:0] EID_OFF_STATUS = 8'h18;
    localparam logic [7:0] EID_OFF_MEM    = 8'h40;
    localparam int unsigned EID_MEM_DEPTH = 16;

    // command word field positions
    localparam int unsigned EID_CMD_OP_LSB   = 0;
    localparam int unsigned EID_CMD_BIT_LSB  = 8;
    localparam int unsigned EID_CMD_ADDR_LSB = 16;

    // status word field positions
    localparam int unsigned EID_ST_BUSY    = 0;
    localparam int unsigned EID_ST_SKIP    = 1;
    localparam int unsigned EID_ST_ILLEGAL = 2;
    localparam int unsigned EID_ST_CYC_LSB = 4;

    // program memory
    localparam int unsigned EID_PROG_AW   = 12;
    localparam int unsigned EID_PAGE_W    = 4;
    localparam logic [3:0]  EID_LAST_PAGE = 4'hf;

    // instruction cycle counts
    localparam logic [3:0] EID_SKIP_CYCLES = 4'h3;

    // reset values
    localparam logic [7:0] EID_BYTE_RST  = 8'h00;
    localparam logic [5:0] EID_FLAGS_RST = 6'h00;

    typedef enum logic [4:0] {
        EID_NOP      = 5'b00000,
        EID_ROR      = 5'b00001,
        EID_RORA     = 5'b00010,
        EID_RORC     = 5'b00011,
        EID_RORCA    = 5'b00100,
        EID_SBC      = 5'b00101,
        EID_SBCM     = 5'b00110,
        EID_SUB      = 5'b00111,
        EID_SUBM     = 5'b01000,
        EID_SDZ      = 5'b01001,
        EID_SDZA     = 5'b01010,
        EID_SIZ      = 5'b01011,
        EID_SIZA     = 5'b01100,
        EID_SET      = 5'b01101,
        EID_SETBIT   = 5'b01110,
        EID_SNZBIT   = 5'b01111,
        EID_SNZ      = 5'b10000,
        EID_SZ       = 5'b10001,
        EID_SZA      = 5'b10010,
        EID_SZBIT    = 5'b10011,
        EID_SWAP     = 5'b10100,
        EID_SWAPA    = 5'b10101,
        EID_TABRD    = 5'b10110,
        EID_TABRDL   = 5'b10111,
        EID_ITABRD   = 5'b11000,
        EID_ITABRDL  = 5'b11001,
        EID_XOR      = 5'b11010,
        EID_XORM     = 5'b11011
    } eid_op_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [2:0] bit_sel;
        eid_op_t    op;
    } eid_cmd_t;

    // bit 0 is carry
    typedef struct packed {
        logic chained_nil_flag;
        logic sub_sign_flag;
        logic signed_wrap_flag;
        logic z;
        logic nibble_out_flag;
        logic c;
    } eid_flags_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       nibble_out;
        logic       signed_wrap;
    } eid_sub_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EXEC   = 2'b01,
        ST_TFETCH = 2'b10,
        ST_DUMMY  = 2'b11
    } eid_state_t;

endpackage

// file: src/eid_datapath.sv
`timescale 1ns/1ps
// Contract
// - rotate_right rotates memory byte, flags kept
// - rotate_right_to_acc loads rotated byte into acc
// - thru-carry rotate: nine-bit ring, memory written
// - thru-carry to acc, carry from bit0
// - borrow subtract: acc minus byte minus not-carry
// - subtraction carry clear if negative, else set
// - memory subtract forms write the data byte
// - subtracts update all six flags
// - plain subtract: acc minus byte only
// - decrement, skip on zero result
// - taken skip costs three cycles total
// - accumulator skip forms leave memory alone
// - increment, skip on zero, no flags
// - set byte ff, set bit, no flags
// - bit test skips on set or clear
// - byte test writes back, skips by value
// - copy to acc, skip if zero
// - nibble exchange in place or to acc
// - page table read via both pointers
// - last page table read via low pointer
// - preincrement low pointer before table read
// - xor to acc or memory, zero flag only
module eid_datapath
    import eid_pkg::*;
(
    // apb slave
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // program memory, asynchronous read of prog_addr
    output logic      [EID_PROG_AW-1:0]    prog_addr,
    output logic                           prog_rd,
    input  wire logic [15:0]               prog_word,
    // core view
    output logic      [7:0]                acc_out,
    output eid_pkg::eid_flags_t            flags_out,
    output logic                           busy,
    output logic                           skip_taken
);
    import eid_pkg::*;

    eid_state_t  state;
    eid_cmd_t    cmd;
    eid_flags_t  flags;
    eid_flags_t  next_flags;
    eid_sub_t    sub_r;
    logic [7:0]  acc;
    logic [7:0]  table_ptr_low;
    logic [7:0]  table_ptr_high;
    logic [7:0]  table_high_latch;
    logic [7:0]  mem [EID_MEM_DEPTH];
    logic [7:0]  ex_m;
    logic [7:0]  res;
    logic [7:0]  next_table_ptr_low;
    logic        wr_mem;
    logic        wr_acc;
    logic        ex_skip;
    logic        ex_tbl;
    logic        ex_last;
    logic        ex_illegal;
    logic        skip_pending;
    logic        illegal;
    logic        rd_done;
    logic [3:0]  cyc;
    logic [3:0]  last_cyc;
    logic        apb_acc;
    logic        wr_fire;
    logic        cmd_fire;
    logic        exec;

    function automatic logic is_mem(input logic [7:0] a);
        return a[7:6] == EID_OFF_MEM[7:6] && a[1:0] == 2'b00;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return is_mem(a) || a == EID_OFF_CMD || a == EID_OFF_ACC || a == EID_OFF_FLAGS
            || a == EID_OFF_TPLO || a == EID_OFF_TPHI || a == EID_OFF_LATCH
            || a == EID_OFF_STATUS;
    endfunction

    // borrow is the inverted carry; carry out is "no borrow"
    function automatic eid_sub_t sub8(input logic [7:0] a, input logic [7:0] b,
                                      input logic bw);
        eid_sub_t   r;
        logic [8:0] d;
        logic [4:0] lo;
        d    = {1'b0, a} - {1'b0, b} - {8'h00, bw};
        lo   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
        r.res = d[7:0];
        r.c   = ~d[8];
        r.nibble_out  = ~lo[4];
        r.signed_wrap = (a[7] ^ b[7]) & (a[7] ^ d[7]);
        return r;
    endfunction

    assign busy      = state != ST_IDLE;
    assign exec      = state == ST_EXEC;
    assign apb_acc   = psel & penable;
    // writes stall while an instruction runs; reads also stall until idle, then take one wait state
    assign pready    = pwrite ? ~busy : rd_done;
    assign pslverr   = apb_acc & pready & ~addr_ok(paddr);
    assign wr_fire   = apb_acc & pwrite & pready & addr_ok(paddr);
    assign cmd_fire  = wr_fire & (paddr == EID_OFF_CMD);
    assign acc_out   = acc;
    assign flags_out = flags;
    assign ex_m      = mem[cmd.addr];

    always_comb begin
        res        = ex_m;
        wr_mem     = 1'b0;
        wr_acc     = 1'b0;
        ex_skip    = 1'b0;
        ex_tbl     = 1'b0;
        ex_last    = 1'b0;
        ex_illegal = 1'b0;
        next_flags = flags;
        next_table_ptr_low = table_ptr_low;
        sub_r      = sub8(acc, ex_m, 1'b0);
        unique case (cmd.op)
            EID_NOP: begin
            end
            EID_ROR, EID_RORA: begin
                res    = {ex_m[0], ex_m[7:1]};
                wr_mem = cmd.op == EID_ROR;
                wr_acc = cmd.op == EID_RORA;
            end
            EID_RORC, EID_RORCA: begin
                res          = {flags.c, ex_m[7:1]};
                next_flags.c = ex_m[0];
                wr_mem       = cmd.op == EID_RORC;
                wr_acc       = cmd.op == EID_RORCA;
            end
            EID_SUB, EID_SUBM, EID_SBC, EID_SBCM: begin
                if (cmd.op == EID_SBC || cmd.op == EID_SBCM) begin
                    sub_r = sub8(acc, ex_m, ~flags.c);
                end
                res           = sub_r.res;
                next_flags.c  = sub_r.c;
                next_flags.nibble_out_flag  = sub_r.nibble_out;
                next_flags.signed_wrap_flag = sub_r.signed_wrap;
                next_flags.z                = sub_r.res == 8'h00;
                next_flags.sub_sign_flag    = sub_r.signed_wrap ^ sub_r.res[7];
                // chained zero keeps a multi-byte compare honest
                next_flags.chained_nil_flag = (cmd.op == EID_SBC || cmd.op == EID_SBCM)
                    ? (next_flags.z & flags.chained_nil_flag) : next_flags.z;
                wr_mem = cmd.op == EID_SUBM || cmd.op == EID_SBCM;
                wr_acc = cmd.op == EID_SUB || cmd.op == EID_SBC;
            end
            EID_SDZ, EID_SDZA: begin
                res     = ex_m - 8'h01;
                ex_skip = res == 8'h00;
                wr_mem  = cmd.op == EID_SDZ;
                wr_acc  = cmd.op == EID_SDZA;
            end
            EID_SIZ, EID_SIZA: begin
                res     = ex_m + 8'h01;
                ex_skip = res == 8'h00;
                wr_mem  = cmd.op == EID_SIZ;
                wr_acc  = cmd.op == EID_SIZA;
            end
            EID_SET: begin
                res    = 8'hff;
                wr_mem = 1'b1;
            end
            EID_SETBIT: begin
                res    = ex_m | (8'h01 << cmd.bit_sel);
                wr_mem = 1'b1;
            end
            EID_SNZBIT: ex_skip = ex_m[cmd.bit_sel];
            EID_SZBIT:  ex_skip = ~ex_m[cmd.bit_sel];
            EID_SNZ, EID_SZ: begin
                wr_mem  = 1'b1;
                ex_skip = (cmd.op == EID_SNZ) == (ex_m != 8'h00);
            end
            EID_SZA: begin
                wr_acc  = 1'b1;
                ex_skip = ex_m == 8'h00;
            end
            EID_SWAP, EID_SWAPA: begin
                res    = {ex_m[3:0], ex_m[7:4]};
                wr_mem = cmd.op == EID_SWAP;
                wr_acc = cmd.op == EID_SWAPA;
            end
            EID_TABRD, EID_TABRDL, EID_ITABRD, EID_ITABRDL: begin
                ex_tbl  = 1'b1;
                ex_last = cmd.op == EID_TABRDL || cmd.op == EID_ITABRDL;
                if (cmd.op == EID_ITABRD || cmd.op == EID_ITABRDL) begin
                    next_table_ptr_low = table_ptr_low + 8'h01;
                end
            end
            EID_XOR, EID_XORM: begin
                res          = acc ^ ex_m;
                next_flags.z = res == 8'h00;
                wr_mem       = cmd.op == EID_XORM;
                wr_acc       = cmd.op == EID_XOR;
            end
            default: ex_illegal = 1'b1;
        endcase
    end

    // sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE:   if (cmd_fire && !skip_pending) state <= ST_EXEC;
                ST_EXEC:   state <= ex_tbl ? ST_TFETCH : (ex_skip ? ST_DUMMY : ST_IDLE);
                ST_TFETCH: state <= ST_IDLE;
                ST_DUMMY:  if (cyc == EID_SKIP_CYCLES - 4'h1) state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc      <= 4'h0;
            last_cyc <= 4'h0;
        end else if (busy) begin
            cyc <= cyc + 4'h1;
            if ((state == ST_EXEC && !ex_tbl && !ex_skip) || state == ST_TFETCH
                || (state == ST_DUMMY && cyc == EID_SKIP_CYCLES - 4'h1)) begin
                last_cyc <= cyc + 4'h1;
                cyc      <= 4'h0;
            end
        end
    end

    // a pending skip swallows the next command as a no-op
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_pending <= 1'b0;
            skip_taken   <= 1'b0;
        end else begin
            skip_taken <= exec && ex_skip;
            if (exec && ex_skip) begin
                skip_pending <= 1'b1;
            end else if (cmd_fire) begin
                skip_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= '{addr: 4'h0, bit_sel: 3'h0, op: EID_NOP};
        end else if (cmd_fire && !skip_pending) begin
            cmd.op      <= eid_op_t'(pwdata[EID_CMD_OP_LSB +: 5]);
            cmd.bit_sel <= pwdata[EID_CMD_BIT_LSB +: 3];
            cmd.addr    <= pwdata[EID_CMD_ADDR_LSB +: 4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            illegal <= 1'b0;
        end else if (exec) begin
            illegal <= ex_illegal;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= EID_BYTE_RST;
        end else if (wr_fire && paddr == EID_OFF_ACC) begin
            acc <= pwdata[7:0];
        end else if (exec && wr_acc) begin
            acc <= res;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= EID_FLAGS_RST;
        end else if (wr_fire && paddr == EID_OFF_FLAGS) begin
            flags <= pwdata[5:0];
        end else if (exec) begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < EID_MEM_DEPTH; i++) begin
                mem[i] <= EID_BYTE_RST;
            end
        end else if (wr_fire && is_mem(paddr)) begin
            mem[paddr[5:2]] <= pwdata[7:0];
        end else if (exec && wr_mem) begin
            mem[cmd.addr] <= res;
        end else if (state == ST_TFETCH) begin
            mem[cmd.addr] <= prog_word[7:0];
        end
    end

    // table pointers and high-byte latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_ptr_low    <= EID_BYTE_RST;
            table_ptr_high   <= EID_BYTE_RST;
            table_high_latch <= EID_BYTE_RST;
        end else begin
            if (wr_fire && paddr == EID_OFF_TPLO) begin
                table_ptr_low <= pwdata[7:0];
            end else if (exec) begin
                table_ptr_low <= next_table_ptr_low;
            end
            if (wr_fire && paddr == EID_OFF_TPHI) begin
                table_ptr_high <= pwdata[7:0];
            end
            if (state == ST_TFETCH) begin
                table_high_latch <= prog_word[15:8];
            end
        end
    end

    // the updated low pointer is used, so an increment lands before the read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_addr <= '0;
            prog_rd   <= 1'b0;
        end else begin
            prog_rd <= exec && ex_tbl;
            if (exec && ex_tbl) begin
                prog_addr <= {ex_last ? EID_LAST_PAGE : table_ptr_high[EID_PAGE_W-1:0],
                              next_table_ptr_low};
            end
        end
    end

    // read data is registered one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            rd_done <= 1'b0;
        end else if (apb_acc && !pwrite && !busy && !rd_done) begin
            rd_done <= 1'b1;
            prdata  <= 32'h0000_0000;
            if (is_mem(paddr)) begin
                prdata[7:0] <= mem[paddr[5:2]];
            end else begin
                unique case (paddr)
                    EID_OFF_CMD:    prdata[20:0] <= {1'b0, cmd.addr, 5'h00, cmd.bit_sel,
                                                     3'h0, cmd.op};
                    EID_OFF_ACC:    prdata[7:0]  <= acc;
                    EID_OFF_FLAGS:  prdata[5:0]  <= flags;
                    EID_OFF_TPLO:   prdata[7:0]  <= table_ptr_low;
                    EID_OFF_TPHI:   prdata[7:0]  <= table_ptr_high;
                    EID_OFF_LATCH:  prdata[7:0]  <= table_high_latch;
                    EID_OFF_STATUS: prdata[7:0]  <= {last_cyc, 1'b0, illegal,
                                                     skip_pending, busy};
                    default:        prdata       <= 32'h0000_0000;
                endcase
            end
        end else if (rd_done) begin
            rd_done <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_rotate_mem: assert property (exec && cmd.op == EID_ROR |=>
        mem[cmd.addr] == {$past(ex_m[0]), $past(ex_m[7:1])} && flags == $past(flags))
        else $error("rotate to memory wrong");
    chk_rotate_acc: assert property (exec && cmd.op == EID_RORA |=>
        acc == {$past(ex_m[0]), $past(ex_m[7:1])} && mem[cmd.addr] == $past(ex_m))
        else $error("rotate to acc wrong");
    chk_rotc_carry: assert property (exec && cmd.op inside {EID_RORC, EID_RORCA} |=>
        flags.c == $past(ex_m[0])
        && (cmd.op == EID_RORC ? mem[cmd.addr][7] : acc[7]) == $past(flags.c))
        else $error("carry rotate wrong");
    chk_sub_plain: assert property (exec && cmd.op == EID_SUB |=>
        acc == 8'($past(acc) - $past(ex_m)) && flags.c == ($past(acc) >= $past(ex_m)))
        else $error("subtract wrong");
    chk_sbc_value: assert property (exec && cmd.op == EID_SBC |=>
        acc == 8'($past(acc) - $past(ex_m) - {7'h00, ~$past(flags.c)}))
        else $error("subtract with borrow wrong");
    chk_skip_three: assert property (exec && ex_skip |=>
        state == ST_DUMMY [*2] ##1 state == ST_IDLE && last_cyc == EID_SKIP_CYCLES)
        else $error("skip not three cycles");
    chk_skip_nop: assert property (cmd_fire && skip_pending |=>
        state == ST_IDLE && !skip_pending && acc == $past(acc) && cmd == $past(cmd))
        else $error("skipped command had effect");
    chk_set_byte: assert property (exec && cmd.op == EID_SET |=>
        mem[cmd.addr] == 8'hff && flags == $past(flags))
        else $error("set byte wrong");
    chk_xor_flags: assert property (exec && cmd.op == EID_XOR |=>
        acc == ($past(acc) ^ $past(ex_m)) && flags.c == $past(flags.c))
        else $error("xor wrong");
    chk_table_hi: assert property (state == ST_TFETCH && prog_rd |=>
        table_high_latch == $past(prog_word[15:8]) && mem[cmd.addr] == $past(prog_word[7:0]))
        else $error("table read wrong");
    chk_preinc_ptr: assert property (exec && cmd.op == EID_ITABRDL |=>
        table_ptr_low == 8'($past(table_ptr_low) + 8'h01)
        && prog_addr == {EID_LAST_PAGE, table_ptr_low})
        else $error("preincrement wrong");

    cov_skip_taken: cover property (exec && ex_skip);
    cov_table_read: cover property (state == ST_TFETCH);
    cov_suppressed: cover property (cmd_fire && skip_pending);
    cov_sub_neg:    cover property (exec && cmd.op == EID_SUBM && !next_flags.c);

endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
    import eid_pkg::*;
    logic        pclk    = 1'h0;
    logic        presetn = 1'h0;
    logic        psel    = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite  = 1'h0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] prog_addr;
    logic        prog_rd;
    logic [15:0] prog_word;
    logic [7:0]  acc_out;
    eid_flags_t  flags_out;
    logic        busy;
    logic        skip_taken;
    logic [31:0] rd;
    logic        err;
    logic        sk;
    logic        pr;
    logic [7:0]  p;
    int          cyc;
    int          cycles      = 0;
    int          n_errors    = 0;
    int          check_count = 0;

    always #12.5 pclk = ~pclk;
    // page sits in the high byte, low pointer in the low byte: every fetch is traceable
    assign prog_word = {4'h0, prog_addr};

    eid_datapath dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_word(prog_word),
        .acc_out(acc_out), .flags_out(flags_out), .busy(busy), .skip_taken(skip_taken));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one idle edge first, so psel is never driven twice in one time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic run(input eid_op_t op, input logic [2:0] b);
        apb(1'h1, EID_OFF_CMD, (32'(op) << EID_CMD_OP_LSB) | (32'(b) << EID_CMD_BIT_LSB)
            | (32'h3 << EID_CMD_ADDR_LSB));
        cyc = 0;
        sk = 1'h0;
        pr = 1'h0;
        do begin
            @(posedge pclk);
            cyc++;
            sk |= skip_taken;
            pr |= prog_rd;
        end while (busy === 1'h1);
        cyc--;
    endtask

    task automatic vec(input eid_op_t op, input logic [2:0] b, input logic [7:0] a, m,
        input logic [5:0] f, input logic [7:0] ea, em, input logic [5:0] ef, input logic k);
        apb(1'h1, EID_OFF_ACC, {24'h0, a});
        apb(1'h1, EID_OFF_MEM + 8'h0c, {24'h0, m});
        apb(1'h1, EID_OFF_FLAGS, {26'h0, f});
        run(op, b);
        chk("skip", {31'h0, k}, {31'h0, sk});
        chk("cycles", k ? 32'h3 : 32'h1, 32'(cyc));
        // a skipped follow-up must leave the byte untouched
        if (k) begin
            apb(1'h0, EID_OFF_STATUS, 32'h0);
            chk("status", 32'h32, rd);
            run(EID_SET, 3'h0);
        end
        chk("acc", {24'h0, ea}, {24'h0, acc_out});
        chk("flags", {26'h0, ef}, {26'h0, flags_out});
        apb(1'h0, EID_OFF_MEM + 8'h0c, 32'h0);
        chk("mem", {24'h0, em}, rd);
        $display("test %s done", op.name());
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        chk("rst acc", 32'h0, {24'h0, acc_out});
        vec(EID_ROR,    3'h0, 8'h00, 8'h81, 6'h3f, 8'h00, 8'hc0, 6'h3f, 1'h0);
        vec(EID_RORA,   3'h0, 8'h11, 8'h02, 6'h00, 8'h01, 8'h02, 6'h00, 1'h0);
        vec(EID_RORC,   3'h0, 8'h00, 8'h01, 6'h00, 8'h00, 8'h00, 6'h01, 1'h0);
        vec(EID_RORCA,  3'h0, 8'h00, 8'h80, 6'h01, 8'hc0, 8'h80, 6'h00, 1'h0);
        vec(EID_SBC,    3'h0, 8'h80, 8'h00, 6'h00, 8'h7f, 8'h00, 6'h19, 1'h0);
        vec(EID_SUB,    3'h0, 8'h05, 8'h03, 6'h00, 8'h02, 8'h03, 6'h03, 1'h0);
        vec(EID_SUBM,   3'h0, 8'h03, 8'h05, 6'h00, 8'h03, 8'hfe, 6'h10, 1'h0);
        vec(EID_SBCM,   3'h0, 8'h05, 8'h05, 6'h21, 8'h05, 8'h00, 6'h27, 1'h0);
        vec(EID_SDZ,    3'h0, 8'h00, 8'h01, 6'h00, 8'h00, 8'h00, 6'h00, 1'h1);
        vec(EID_SDZA,   3'h0, 8'h00, 8'h05, 6'h00, 8'h04, 8'h05, 6'h00, 1'h0);
        vec(EID_SIZ,    3'h0, 8'h00, 8'hff, 6'h3f, 8'h00, 8'h00, 6'h3f, 1'h1);
        vec(EID_SIZA,   3'h0, 8'h12, 8'hff, 6'h00, 8'h00, 8'hff, 6'h00, 1'h1);
        vec(EID_SET,    3'h0, 8'h00, 8'h12, 6'h00, 8'h00, 8'hff, 6'h00, 1'h0);
        vec(EID_SETBIT, 3'h3, 8'h00, 8'h00, 6'h15, 8'h00, 8'h08, 6'h15, 1'h0);
        vec(EID_SNZBIT, 3'h7, 8'h00, 8'h80, 6'h00, 8'h00, 8'h80, 6'h00, 1'h1);
        vec(EID_SNZBIT, 3'h6, 8'h00, 8'hbf, 6'h00, 8'h00, 8'hbf, 6'h00, 1'h0);
        vec(EID_SZBIT,  3'h0, 8'h00, 8'hfe, 6'h00, 8'h00, 8'hfe, 6'h00, 1'h1);
        vec(EID_SNZ,    3'h0, 8'h00, 8'h00, 6'h00, 8'h00, 8'h00, 6'h00, 1'h0);
        vec(EID_SZ,     3'h0, 8'h00, 8'h00, 6'h00, 8'h00, 8'h00, 6'h00, 1'h1);
        vec(EID_SZA,    3'h0, 8'h77, 8'h00, 6'h00, 8'h00, 8'h00, 6'h00, 1'h1);
        vec(EID_SWAP,   3'h0, 8'h00, 8'h12, 6'h00, 8'h00, 8'h21, 6'h00, 1'h0);
        vec(EID_SWAPA,  3'h0, 8'h00, 8'hab, 6'h00, 8'hba, 8'hab, 6'h00, 1'h0);
        vec(EID_XOR,    3'h0, 8'hf0, 8'hf0, 6'h21, 8'h00, 8'hf0, 6'h25, 1'h0);
        vec(EID_XORM,   3'h0, 8'h0f, 8'hf0, 6'h04, 8'h0f, 8'hff, 6'h00, 1'h0);
        apb(1'h1, EID_OFF_TPLO, 32'h7e);
        apb(1'h1, EID_OFF_TPHI, 32'h3);
        p = 8'h7e;
        for (int i = 0; i < 4; i++) begin
            if (i >= 2) p++;
            run(eid_op_t'(32'(EID_TABRD) + i), 3'h0);
            chk("tab cycles", 32'h2, 32'(cyc));
            chk("prog rd", 32'h1, {31'h0, pr});
            apb(1'h0, EID_OFF_MEM + 8'h0c, 32'h0);
            chk("tab low", {24'h0, p}, rd);
            apb(1'h0, EID_OFF_LATCH, 32'h0);
            chk("tab high", i[0] ? 32'hf : 32'h3, rd);
            apb(1'h0, EID_OFF_TPLO, 32'h0);
            chk("tab ptr", {24'h0, p}, rd);
        end
        $display("test table reads done");
        apb(1'h0, 8'h20, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("test unmapped done");
        run(eid_op_t'(5'h1f), 3'h0);
        chk("ill cycles", 32'h1, 32'(cyc));
        apb(1'h0, EID_OFF_STATUS, 32'h0);
        chk("ill status", 32'h14, rd);
        apb(1'h0, EID_OFF_CMD, 32'h0);
        chk("cmd readback", 32'h0003_001f, rd);
        run(EID_NOP, 3'h0);
        apb(1'h0, EID_OFF_STATUS, 32'h0);
        chk("nop status", 32'h10, rd);
        $display("test illegal done");
        wrap_up();
    end
endmodule
